// ==== rtl/periph_defines.svh ====
// Register offsets, field positions, reset values and sizes for the peripheral interface
//
// Overview of operation
// - Mode register, read/write, resets to zero
// - Data register exchanges words with peripheral
// - Status register is read-only
// - Set register ones set status bits
// - Clear register ones clear status bits
// - Zero bits in set/clear change nothing
// - Bits above the 8-bit fields read zero; unused bits inside them are stored as written
// - Interrupt is OR of status AND mask
// - Mask changes only via enable/disable writes
// - One receive and one transmit channel
// - Channel has 32-bit pointer, 16-bit count
// - Channel completion raises end-of-transfer status
// - One transfer moves up to 65535 items of the programmed size
// - Command register write-only, ones trigger
// - Word access only, low address bits ignored
`ifndef PERIPH_DEFINES_SVH
`define PERIPH_DEFINES_SVH

// Byte offsets inside the 16-Kbyte window
`define ADDR_WIDTH 14
`define OFS_COMMAND 14'h0000
`define OFS_MODE 14'h0004
`define OFS_STAT_SET 14'h0008
`define OFS_STAT_CLR 14'h000C
`define OFS_STATUS 14'h0010
`define OFS_IRQ_EN 14'h0014
`define OFS_IRQ_DIS 14'h0018
`define OFS_IRQ_MASK 14'h001C
`define OFS_RX_DATA 14'h0020
`define OFS_TX_DATA 14'h0024
`define OFS_RX_PTR 14'h0030
`define OFS_RX_CNT 14'h0034
`define OFS_TX_PTR 14'h0038
`define OFS_TX_CNT 14'h003C

// Command bits
`define CMD_RX_FLUSH 0
`define CMD_TX_FLUSH 1

// Mode fields
`define MODE_WIDTH 8
`define MODE_RESET 8'h00
`define MODE_RX_EN 0
`define MODE_TX_EN 1
`define MODE_SIZE_LSB 2

// Status bits; bits 0 and 1 are live, the rest sticky
`define STAT_WIDTH 8
`define STAT_RESET 8'h00
`define STAT_RX_READY 0
`define STAT_TX_READY 1
`define STAT_END_RX 2
`define STAT_END_TX 3
`define STAT_OVERRUN 4
`define STAT_STICKY 8'hFC
`define MASK_RESET 8'h00

// Channel and buffer sizes
`define PTR_WIDTH 32
`define CNT_WIDTH 16
`define FIFO_DEPTH 16

`endif

// ==== rtl/periph_pkg.sv ====
// Shared types for the peripheral interface
package periph_pkg;
  // Block transfer channel sequencing
  typedef enum logic [0:0] {CH_IDLE, CH_BUSY} chan_state_e;
  // Item size code: 0 byte, 1 half-word, 2 word
  typedef logic [1:0] item_size_t;
endpackage

// ==== rtl/xfer_if.sv ====
// Programming and status signals between register bank and one transfer channel
interface xfer_if;
  logic ld_ptr;
  logic ld_cnt;
  logic [31:0] wdata;
  logic [31:0] ptr;
  logic [15:0] cnt;
  logic busy;
  logic done;
  modport ctrl (output ld_ptr, output ld_cnt, output wdata, input ptr, input cnt, input busy, input done);
  modport chan (input ld_ptr, input ld_cnt, input wdata, output ptr, output cnt, output busy, output done);
endinterface

// ==== rtl/sync_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides and flush
module sync_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_s;
  fifo_s q_r, q_nxt;
  logic full, empty;

  // Extra pointer bit tells full from empty
  assign empty = (q_r.wp == q_r.rp);
  assign full = (q_r.wp[AW] != q_r.rp[AW]) && (q_r.wp[AW-1:0] == q_r.rp[AW-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = q_r.mem[q_r.rp[AW-1:0]];

  // Pointer and storage update
  always_comb begin
    q_nxt = q_r;
    if (in_valid_i && !full) begin
      q_nxt.mem[q_r.wp[AW-1:0]] = in_data_i;
      q_nxt.wp = q_r.wp + 1'b1;
    end
    if (out_ready_i && !empty) begin
      q_nxt.rp = q_r.rp + 1'b1;
    end
    if (flush_i) begin
      q_nxt.rp = q_nxt.wp;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule // sync_fifo

// ==== rtl/xfer_channel.sv ====
// One block transfer channel: pointer, count and memory request sequencing
`include "periph_defines.svh"
module xfer_channel (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Programming
  xfer_if.chan prog,
  input wire logic enable_i,
  input wire periph_pkg::item_size_t size_i,
  // Buffer side
  input wire logic avail_i,
  input wire logic [31:0] item_i,
  output logic step_o,
  // Memory side
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i
);
  typedef struct packed {
    periph_pkg::chan_state_e st;
    logic [`PTR_WIDTH-1:0] ptr;
    logic [`CNT_WIDTH-1:0] cnt;
    logic [31:0] data;
    logic done;
  } chan_s;
  chan_s s_r, s_nxt;

  // Byte step per item
  function automatic logic [31:0] size_bytes(input periph_pkg::item_size_t sz);
    size_bytes = (sz == 2'h0) ? 32'h1 : (sz == 2'h1) ? 32'h2 : 32'h4;
  endfunction

  assign step_o = (s_r.st == periph_pkg::CH_BUSY) && mem_ack_i;
  assign mem_req_o = (s_r.st == periph_pkg::CH_BUSY);
  assign mem_addr_o = s_r.ptr;
  assign mem_wdata_o = s_r.data;
  assign prog.ptr = s_r.ptr;
  assign prog.cnt = s_r.cnt;
  assign prog.busy = (s_r.cnt != '0);
  assign prog.done = s_r.done;

  // Sequencing; a 16-bit item count covers up to 65535 items
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      periph_pkg::CH_IDLE: begin
        if (enable_i && (s_r.cnt != '0) && avail_i) begin
          s_nxt.data = item_i;
          s_nxt.st = periph_pkg::CH_BUSY;
        end
      end
      periph_pkg::CH_BUSY: begin
        if (mem_ack_i) begin
          s_nxt.ptr = s_r.ptr + size_bytes(size_i);
          s_nxt.cnt = s_r.cnt - 1'b1;
          s_nxt.done = (s_r.cnt == 16'h0001);
          s_nxt.st = periph_pkg::CH_IDLE;
        end
      end
      default: s_nxt.st = periph_pkg::CH_IDLE;
    endcase
    // Software loads win over the running update
    if (prog.ld_ptr) begin
      s_nxt.ptr = prog.wdata;
    end
    if (prog.ld_cnt) begin
      s_nxt.cnt = prog.wdata[`CNT_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{st: periph_pkg::CH_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // xfer_channel

// ==== rtl/periph_reg_irq_xfer_iface.sv ====
// Common peripheral register bank with interrupt mask, data buffers and two transfer channels
`include "periph_defines.svh"
module periph_reg_irq_xfer_iface #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register access port
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [`ADDR_WIDTH-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // Interrupt source to the vectored_irq_controller
  output logic irq_o,
  // Receive stream from peripheral core
  input wire logic rx_valid_i,
  input wire logic [31:0] rx_data_i,
  output logic rx_ready_o,
  // Transmit stream to peripheral core
  output logic tx_valid_o,
  output logic [31:0] tx_data_o,
  input wire logic tx_ready_i,
  // Receive channel memory writes
  output logic rxm_req_o,
  output logic [31:0] rxm_addr_o,
  output logic [31:0] rxm_wdata_o,
  output logic [1:0] rxm_size_o,
  input wire logic rxm_ack_i,
  // Transmit channel memory reads
  output logic txm_req_o,
  output logic [31:0] txm_addr_o,
  output logic [1:0] txm_size_o,
  input wire logic txm_ack_i,
  input wire logic [31:0] txm_rdata_i
);
  typedef struct packed {
    logic [`MODE_WIDTH-1:0] mode;
    logic [`STAT_WIDTH-1:0] status;
    logic [`STAT_WIDTH-1:0] mask;
    logic [31:0] rdata;
  } bank_s;
  bank_s b_r, b_nxt;

  xfer_if rx_prog ();
  xfer_if tx_prog ();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // Word match only, so byte and half-word offsets fold onto their word
  function automatic logic word_hit(input logic [`ADDR_WIDTH-1:0] a, input logic [`ADDR_WIDTH-1:0] ofs);
    word_hit = (a[`ADDR_WIDTH-1:2] == ofs[`ADDR_WIDTH-1:2]);
  endfunction

  logic wr, rd;
  logic wr_cmd, wr_mode, wr_set, wr_clr, wr_ien, wr_idis, wr_txd;
  logic rd_rxd;
  assign wr = reg_sel_i && reg_wr_i;
  assign rd = reg_sel_i && !reg_wr_i;
  assign wr_cmd = wr && word_hit(reg_addr_i, `OFS_COMMAND);
  assign wr_mode = wr && word_hit(reg_addr_i, `OFS_MODE);
  assign wr_set = wr && word_hit(reg_addr_i, `OFS_STAT_SET);
  assign wr_clr = wr && word_hit(reg_addr_i, `OFS_STAT_CLR);
  assign wr_ien = wr && word_hit(reg_addr_i, `OFS_IRQ_EN);
  assign wr_idis = wr && word_hit(reg_addr_i, `OFS_IRQ_DIS);
  assign wr_txd = wr && word_hit(reg_addr_i, `OFS_TX_DATA);
  assign rd_rxd = rd && word_hit(reg_addr_i, `OFS_RX_DATA);

  // Channel programming strobes
  assign rx_prog.ld_ptr = wr && word_hit(reg_addr_i, `OFS_RX_PTR);
  assign rx_prog.ld_cnt = wr && word_hit(reg_addr_i, `OFS_RX_CNT);
  assign tx_prog.ld_ptr = wr && word_hit(reg_addr_i, `OFS_TX_PTR);
  assign tx_prog.ld_cnt = wr && word_hit(reg_addr_i, `OFS_TX_CNT);
  assign rx_prog.wdata = reg_wdata_i;
  assign tx_prog.wdata = reg_wdata_i;

  // Commands act for one cycle only; nothing is stored
  logic rx_flush, tx_flush;
  assign rx_flush = wr_cmd && reg_wdata_i[`CMD_RX_FLUSH];
  assign tx_flush = wr_cmd && reg_wdata_i[`CMD_TX_FLUSH];

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and channel

  logic rxf_valid, rxf_pop;
  logic [31:0] rxf_data;
  logic rx_step;

  sync_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .flush_i(rx_flush),
    .in_valid_i(rx_valid_i),
    .in_data_i(rx_data_i),
    .in_ready_o(rx_ready_o),
    .out_valid_o(rxf_valid),
    .out_data_o(rxf_data),
    .out_ready_i(rxf_pop)
  );

  xfer_channel u_rx_chan (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .prog(rx_prog.chan),
    .enable_i(b_r.mode[`MODE_RX_EN]),
    .size_i(b_r.mode[`MODE_SIZE_LSB +: 2]),
    .avail_i(rxf_valid),
    .item_i(rxf_data),
    .step_o(rx_step),
    .mem_req_o(rxm_req_o),
    .mem_addr_o(rxm_addr_o),
    .mem_wdata_o(rxm_wdata_o),
    .mem_ack_i(rxm_ack_i)
  );

  // A programmed channel owns the buffer; otherwise data register reads drain it
  assign rxf_pop = rx_prog.busy ? rx_step : (rd_rxd && rxf_valid);
  assign rxm_size_o = b_r.mode[`MODE_SIZE_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and channel

  logic txf_ready, txf_push;
  logic [31:0] txf_data;
  logic tx_step;

  xfer_channel u_tx_chan (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .prog(tx_prog.chan),
    .enable_i(b_r.mode[`MODE_TX_EN]),
    .size_i(b_r.mode[`MODE_SIZE_LSB +: 2]),
    .avail_i(txf_ready),
    .item_i(32'h0000_0000),
    .step_o(tx_step),
    .mem_req_o(txm_req_o),
    .mem_addr_o(txm_addr_o),
    .mem_wdata_o(),
    .mem_ack_i(txm_ack_i)
  );

  // Room is checked before the read is issued, so the returned word always fits
  assign txf_push = tx_prog.busy ? tx_step : (wr_txd && txf_ready);
  assign txf_data = tx_prog.busy ? txm_rdata_i : reg_wdata_i;
  assign txm_size_o = b_r.mode[`MODE_SIZE_LSB +: 2];

  sync_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .flush_i(tx_flush),
    .in_valid_i(txf_push),
    .in_data_i(txf_data),
    .in_ready_o(txf_ready),
    .out_valid_o(tx_valid_o),
    .out_data_o(tx_data_o),
    .out_ready_i(tx_ready_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status view and interrupt

  logic [`STAT_WIDTH-1:0] live, view, hw_set;
  logic overrun;

  // Writes to a full buffer, or data writes while a channel owns it, are lost
  assign overrun = wr_txd && (tx_prog.busy || !txf_ready);

  always_comb begin
    live = '0;
    live[`STAT_RX_READY] = rxf_valid;
    live[`STAT_TX_READY] = txf_ready;
    hw_set = '0;
    hw_set[`STAT_END_RX] = rx_prog.done;
    hw_set[`STAT_END_TX] = tx_prog.done;
    hw_set[`STAT_OVERRUN] = overrun;
  end

  assign view = b_r.status | live;
  // Level held while any unmasked bit stays set
  assign irq_o = |(view & b_r.mask);
  assign reg_rdata_o = b_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Register state update

  always_comb begin
    b_nxt = b_r;
    // Mode stores all eight written low bits, defined or not
    if (wr_mode) begin
      b_nxt.mode = reg_wdata_i[`MODE_WIDTH-1:0];
    end
    // Clear first, then set and hardware events, so a set never gets lost
    b_nxt.status = b_r.status & ~({`STAT_WIDTH{wr_clr}} & reg_wdata_i[`STAT_WIDTH-1:0]);
    b_nxt.status = b_nxt.status | ({`STAT_WIDTH{wr_set}} & reg_wdata_i[`STAT_WIDTH-1:0]);
    b_nxt.status = (b_nxt.status | hw_set) & `STAT_STICKY;
    // Mask moves only through enable and disable writes
    if (wr_ien) begin
      b_nxt.mask = b_r.mask | reg_wdata_i[`STAT_WIDTH-1:0];
    end
    if (wr_idis) begin
      b_nxt.mask = b_r.mask & ~reg_wdata_i[`STAT_WIDTH-1:0];
    end
    // Read data; write-only and unmapped words read zero
    if (rd) begin
      b_nxt.rdata = 32'h0000_0000;
      if (word_hit(reg_addr_i, `OFS_MODE)) begin
        b_nxt.rdata[`MODE_WIDTH-1:0] = b_r.mode;
      end else if (word_hit(reg_addr_i, `OFS_STATUS)) begin
        b_nxt.rdata[`STAT_WIDTH-1:0] = view;
      end else if (word_hit(reg_addr_i, `OFS_IRQ_MASK)) begin
        b_nxt.rdata[`STAT_WIDTH-1:0] = b_r.mask;
      end else if (word_hit(reg_addr_i, `OFS_RX_DATA)) begin
        b_nxt.rdata = rxf_valid ? rxf_data : 32'h0000_0000;
      end else if (word_hit(reg_addr_i, `OFS_RX_PTR)) begin
        b_nxt.rdata = rx_prog.ptr;
      end else if (word_hit(reg_addr_i, `OFS_RX_CNT)) begin
        b_nxt.rdata[`CNT_WIDTH-1:0] = rx_prog.cnt;
      end else if (word_hit(reg_addr_i, `OFS_TX_PTR)) begin
        b_nxt.rdata = tx_prog.ptr;
      end else if (word_hit(reg_addr_i, `OFS_TX_CNT)) begin
        b_nxt.rdata[`CNT_WIDTH-1:0] = tx_prog.cnt;
      end
    end
  end

  // Status has no write path of its own; only set/clear writes and hardware events reach it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      b_r <= '{mode: `MODE_RESET, status: `STAT_RESET, mask: `MASK_RESET, rdata: 32'h0000_0000};
    end else begin
      b_r <= b_nxt;
    end
  end
endmodule // periph_reg_irq_xfer_iface

// ==== sim/periph_iface_properties.sv ====
// Concurrent checks on the peripheral interface top ports
`include "periph_defines.svh"
module periph_iface_properties (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [`ADDR_WIDTH-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  // Interrupt and memory requests
  input wire logic irq_o,
  input wire logic rxm_req_o,
  input wire logic [31:0] rxm_addr_o,
  input wire logic rxm_ack_i,
  input wire logic txm_req_o,
  input wire logic [31:0] txm_addr_o,
  input wire logic txm_ack_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  // Single register accesses, low address bits folded away
  sequence s_rd(logic [13:0] a);
    reg_sel_i && !reg_wr_i && reg_addr_i[13:2] == a[13:2];
  endsequence
  sequence s_wr(logic [13:0] a);
    reg_sel_i && reg_wr_i && reg_addr_i[13:2] == a[13:2];
  endsequence
  ////////////////////////////////////////////////////////////
  chk_mode_back: assert property (s_wr(`OFS_MODE) ##2 s_rd(`OFS_MODE) |=>
    reg_rdata_o == ($past(reg_wdata_i, 3) & 32'h000000FF)) else $error("mode readback wrong");
  chk_mask_back: assert property (s_wr(`OFS_IRQ_EN) ##2 s_rd(`OFS_IRQ_MASK) |=>
    (reg_rdata_o & $past(reg_wdata_i, 3)) == ($past(reg_wdata_i, 3) & 32'h000000FF)) else $error("mask not set");
  chk_irq_off: assert property (s_wr(`OFS_IRQ_DIS) ##0 reg_wdata_i[7:0] == 8'hFF |=> !irq_o)
    else $error("irq with mask cleared");
  chk_cmd_zero: assert property (s_rd(`OFS_COMMAND) |=> reg_rdata_o == 32'h0)
    else $error("command reads nonzero");
  chk_unmapped_zero: assert property (s_rd(14'h0028) |=> reg_rdata_o == 32'h0)
    else $error("unmapped reads nonzero");
  chk_rdata_hold: assert property (!(reg_sel_i && !reg_wr_i) |=> $stable(reg_rdata_o))
    else $error("read data moved");
  chk_rreq_hold: assert property (rxm_req_o && !rxm_ack_i |=> rxm_req_o && $stable(rxm_addr_o))
    else $error("rx request dropped");
  chk_treq_hold: assert property (txm_req_o && !txm_ack_i |=> txm_req_o && $stable(txm_addr_o))
    else $error("tx request dropped");
  chk_item_gap: assert property (rxm_req_o && rxm_ack_i |=> !rxm_req_o)
    else $error("rx item not closed");
endmodule // periph_iface_properties

bind periph_reg_irq_xfer_iface periph_iface_properties periph_iface_properties_inst (.clock_i, .rst_i,
  .reg_sel_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .irq_o, .rxm_req_o, .rxm_addr_o,
  .rxm_ack_i, .txm_req_o, .txm_addr_o, .txm_ack_i);

// ==== sim/mem_model.sv ====
// Memory responder for one transfer channel
module mem_model (
  // Clock
  input wire logic clock_i,
  // Request side
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] dly_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] log_a [8];
  logic [31:0] log_d [8];
  int n = 0;
  int w = 0;
  initial begin
    ack_o = 1'h0;
    rdata_o = 32'h0;
  end
  // Ack after dly_i cycles; read data churns outside the ack cycle
  always @(posedge clock_i) begin
    if (ack_o && req_i) begin
      log_a[n % 8] = addr_i;
      log_d[n % 8] = wdata_i;
      n++;
    end
    #1;
    if (ack_o) ack_o = 1'h0;
    else if (req_i && w >= dly_i) ack_o = 1'h1;
    w = (req_i && !ack_o) ? w + 1 : 0;
    rdata_o = ack_o ? ~addr_i : {rdata_o[30:0], ~rdata_o[31]};
  end
endmodule // mem_model

// ==== sim/tb_periph_reg_irq_xfer_iface.sv ====
// Self-checking bench for the peripheral interface block
`include "periph_defines.svh"
module tb_periph_reg_irq_xfer_iface;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'h0, rst_i = 1'h1, reg_sel_i = 1'h0, reg_wr_i = 1'h0, rx_valid_i = 1'h0, tx_ready_i = 1'h0;
  logic irq_o, rx_ready_o, tx_valid_o, rxm_req_o, rxm_ack_i, txm_req_o, txm_ack_i;
  logic [13:0] reg_addr_i = 14'h0;
  logic [31:0] reg_wdata_i = 32'h0, rx_data_i = 32'h0, v;
  logic [31:0] reg_rdata_o, tx_data_o, rxm_addr_o, rxm_wdata_o, txm_addr_o, txm_rdata_i;
  logic [1:0] rxm_size_o, txm_size_o;
  logic [3:0] dly = 4'h2;
  int n_fail = 0, n_checks = 0;
  // 20 MHz clock
  initial forever #25 clock_i = ~clock_i;
  periph_reg_irq_xfer_iface periph_reg_irq_xfer_iface_inst (.clock_i, .rst_i, .reg_sel_i, .reg_wr_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .irq_o, .rx_valid_i, .rx_data_i, .rx_ready_o, .tx_valid_o,
    .tx_data_o, .tx_ready_i, .rxm_req_o, .rxm_addr_o, .rxm_wdata_o, .rxm_size_o, .rxm_ack_i, .txm_req_o,
    .txm_addr_o, .txm_size_o, .txm_ack_i, .txm_rdata_i);
  mem_model mem_model_inst (.clock_i, .req_i(rxm_req_o), .addr_i(rxm_addr_o), .wdata_i(rxm_wdata_o),
    .dly_i(dly), .ack_o(rxm_ack_i), .rdata_o());
  mem_model mem_model_tx_inst (.clock_i, .req_i(txm_req_o), .addr_i(txm_addr_o), .wdata_i(32'h0),
    .dly_i(dly), .ack_o(txm_ack_i), .rdata_o(txm_rdata_i));
  ////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One access then an idle cycle, so strobes never toggle twice in a step
  task automatic acc(input logic w, input logic [13:0] a, input logic [31:0] d);
    reg_sel_i = 1'h1;
    reg_wr_i = w;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge clock_i) #1;
    v = reg_rdata_o;
    reg_sel_i = 1'h0;
    @(posedge clock_i) #1;
  endtask
  task automatic rc(input string nm, input logic [13:0] a, input logic [31:0] e);
    acc(1'h0, a, 32'h0);
    cmp(nm, e, v);
  endtask
  task automatic ws(input int b);
    v = 32'h0;
    for (int k = 0; k < 40 && v[b] !== 1'h1; k++) acc(1'h0, `OFS_STATUS, 32'h0);
  endtask
  task automatic push(input logic [31:0] d);
    rx_valid_i = 1'h1;
    rx_data_i = d;
    for (int k = 0; k < 40 && rx_ready_o !== 1'h1; k++) @(posedge clock_i) #1;
    @(posedge clock_i) #1;
    rx_valid_i = 1'h0;
    @(posedge clock_i) #1;
  endtask
  task automatic pop(input logic [31:0] e);
    tx_ready_i = 1'h1;
    for (int k = 0; k < 40 && tx_valid_o !== 1'h1; k++) @(posedge clock_i) #1;
    cmp("tx valid", 32'h1, {31'h0, tx_valid_o});
    cmp("tx word", e, tx_data_o);
    @(posedge clock_i) #1;
    tx_ready_i = 1'h0;
    @(posedge clock_i) #1;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    rc("mode", `OFS_MODE, 32'h0);
    rc("status", `OFS_STATUS, 32'h2);
    rc("mask", `OFS_IRQ_MASK, 32'h0);
    cmp("irq", 32'h0, {31'h0, irq_o});
  endtask
  task automatic t_regs;
    acc(1'h1, `OFS_MODE + 14'h1, 32'h000000FF);
    rc("mode", `OFS_MODE + 14'h2, 32'hFF);
    acc(1'h1, `OFS_MODE, 32'h0);
    acc(1'h1, `OFS_STATUS, 32'hFF);
    rc("status", `OFS_STATUS, 32'h2);
    acc(1'h1, `OFS_STAT_SET, 32'hA0);
    rc("status", `OFS_STATUS, 32'hA2);
    acc(1'h1, `OFS_STAT_CLR, 32'h20);
    rc("status", `OFS_STATUS, 32'h82);
    acc(1'h1, `OFS_STAT_SET, 32'h0);
    acc(1'h1, `OFS_STAT_CLR, 32'h0);
    rc("status", `OFS_STATUS, 32'h82);
    acc(1'h1, `OFS_COMMAND, 32'h0);
    rc("command", `OFS_COMMAND, 32'h0);
    rc("unmapped", 14'h0028, 32'h0);
    acc(1'h1, `OFS_RX_CNT, 32'h0000FFFF);
    rc("rx count", `OFS_RX_CNT, 32'hFFFF);
    acc(1'h1, `OFS_RX_CNT, 32'h0);
  endtask
  // Mask grows and shrinks only through enable and disable writes
  task automatic t_irq;
    acc(1'h1, `OFS_IRQ_EN, 32'h80);
    rc("mask", `OFS_IRQ_MASK, 32'h80);
    repeat (3) @(posedge clock_i) #1;
    cmp("irq", 32'h1, {31'h0, irq_o});
    acc(1'h1, `OFS_IRQ_EN, 32'h01);
    rc("mask", `OFS_IRQ_MASK, 32'h81);
    acc(1'h1, `OFS_STAT_CLR, 32'h80);
    cmp("irq", 32'h0, {31'h0, irq_o});
    acc(1'h1, `OFS_IRQ_DIS, 32'hFF);
    rc("mask", `OFS_IRQ_MASK, 32'h0);
  endtask
  // Far side stalls while the transmit buffer fills past its depth
  task automatic t_txfifo;
    for (int i = 0; i < 17; i++) acc(1'h1, `OFS_TX_DATA, 32'hB0000000 + i);
    rc("status", `OFS_STATUS, 32'h10);
    for (int i = 0; i < 16; i++) pop(32'hB0000000 + i);
    acc(1'h1, `OFS_STAT_CLR, 32'h10);
    rc("status", `OFS_STATUS, 32'h2);
    // A queued word must vanish on the transmit flush command
    acc(1'h1, `OFS_TX_DATA, 32'h00000005);
    acc(1'h1, `OFS_COMMAND, 32'h00000002);
    cmp("tx valid", 32'h0, {31'h0, tx_valid_o});
  endtask
  task automatic t_rxfifo;
    for (int i = 0; i < 16; i++) push(32'hC0DE0000 + i);
    cmp("rx ready", 32'h0, {31'h0, rx_ready_o});
    rc("status", `OFS_STATUS, 32'h3);
    for (int i = 0; i < 16; i++) rc("rx data", `OFS_RX_DATA, 32'hC0DE0000 + i);
    push(32'h1);
    acc(1'h1, `OFS_COMMAND, 32'h1);
    rc("status", `OFS_STATUS, 32'h2);
  endtask
  // Two words, word steps, slow memory
  task automatic t_rxchan;
    acc(1'h1, `OFS_RX_PTR, 32'h1000);
    acc(1'h1, `OFS_RX_CNT, 32'h2);
    push(32'h11);
    push(32'h22);
    acc(1'h1, `OFS_IRQ_EN, 32'h04);
    acc(1'h1, `OFS_MODE, 32'h09);
    ws(`STAT_END_RX);
    cmp("irq", 32'h1, {31'h0, irq_o});
    rc("rx ptr", `OFS_RX_PTR, 32'h1008);
    rc("rx count", `OFS_RX_CNT, 32'h0);
    cmp("rx size", 32'h2, {30'h0, rxm_size_o});
    for (int i = 0; i < 2; i++) cmp("rx addr", 32'h1000 + 4 * i, mem_model_inst.log_a[i]);
    for (int i = 0; i < 2; i++) cmp("rx mem", 32'h11 * (i + 1), mem_model_inst.log_d[i]);
    acc(1'h1, `OFS_IRQ_DIS, 32'hFF);
  endtask
  // Half-word steps, prompt memory
  task automatic t_txchan;
    dly = 4'h0;
    acc(1'h1, `OFS_TX_PTR, 32'h2000);
    acc(1'h1, `OFS_TX_CNT, 32'h2);
    acc(1'h1, `OFS_MODE, 32'h06);
    ws(`STAT_END_TX);
    pop(~32'h2000);
    pop(~32'h2002);
    rc("tx ptr", `OFS_TX_PTR, 32'h2004);
    cmp("tx size", 32'h1, {30'h0, txm_size_o});
    rc("status", `OFS_STATUS, 32'h0E);
    // Byte steps: one item moves the pointer by one
    acc(1'h1, `OFS_STAT_CLR, 32'h08);
    acc(1'h1, `OFS_MODE, 32'h02);
    acc(1'h1, `OFS_TX_CNT, 32'h1);
    ws(`STAT_END_TX);
    pop(~32'h2004);
    rc("tx ptr", `OFS_TX_PTR, 32'h2005);
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clock_i);
    #1;
    rst_i = 1'h0;
    t_reset();
    t_regs();
    t_irq();
    t_txfifo();
    t_rxfifo();
    t_rxchan();
    t_txchan();
    wrap_up();
  end
endmodule // tb_periph_reg_irq_xfer_iface
